// *** design/scc_hdlc_serial_config_regs_consts.svh ***
`ifndef SCC_HDLC_SERIAL_CONFIG_REGS_CONSTS_SVH
`define SCC_HDLC_SERIAL_CONFIG_REGS_CONSTS_SVH

// register offsets, byte addresses as printed
`define OFS_CHANNEL_CONFIG 12'h0882
`define OFS_CHANNEL_MODE 12'h0884
`define OFS_SYNC_PATTERN 12'h0886
`define OFS_CHANNEL_EVENTS 12'h0888
`define OFS_EVENT_MASK 12'h088a
`define OFS_LINE_STATUS 12'h088c
`define OFS_TIMESLOT_MASK 12'h08b2
`define OFS_IFACE_SETUP 12'h08b4

// reset values
`define RST_SYNC_PATTERN 16'h7e7e
`define RST_ZERO16 16'h0000
`define RST_ZERO8 8'h00

// serial_channel_config fields
`define CFG_WIRED_OR 15
`define CFG_EXT_BAUD 14
`define CFG_TX_CLK_SEL 13
`define CFG_RX_CLK_SEL 12
`define CFG_DIV_HI 11
`define CFG_DIV_LO 1
`define CFG_PRESCALE4 0

// serial_channel_mode fields
`define MODE_FLAGS_HI 15
`define MODE_FLAGS_LO 12
`define MODE_CRC32 11
`define MODE_FLAG_SHARE 10
`define MODE_RETRANSMIT 8
`define MODE_IDLE_FLAG 7
`define MODE_NRZI 6
`define MODE_DIAG_HI 5
`define MODE_DIAG_LO 4
`define MODE_RX_EN 3
`define MODE_TX_EN 2
`define MODE_PROTO_HI 1
`define MODE_PROTO_LO 0

// serial_interface_setup fields
`define SI_B2_STROBE_SWAP 11
`define SI_B1_STROBE_SWAP 10
`define SI_B2_ROUTE_HI 9
`define SI_B2_ROUTE_LO 8
`define SI_B1_ROUTE_HI 7
`define SI_B1_ROUTE_LO 6
`define SI_D_ROUTE_HI 5
`define SI_D_ROUTE_LO 4
`define SI_CHAN3_DISC 3
`define SI_CHAN2_DISC 2
`define SI_MODE_HI 1
`define SI_MODE_LO 0

// channel_events / channel_event_mask bits
`define EV_CTS 7
`define EV_CD 6
`define EV_IDLE 5
`define EV_TX_ERROR 4
`define EV_RX_FRAME 3
`define EV_NO_BUFFER 2
`define EV_TX_BUFFER 1
`define EV_RX_BUFFER 0

// channel_line_status bits
`define ST_IDLE 2
`define ST_CD 1
`define ST_CTS 0

// synchronised pin indices
`define PIN_CTS 0
`define PIN_CD 1
`define PIN_RXD 2
`define PIN_TIMER 3
`define PIN_TX_CLOCK_PIN 4
`define PIN_RCLK 5

// field encodings
`define ROUTE_NONE 2'b00
`define ROUTE_CH2 2'b10
`define ROUTE_CH3 2'b11
`define IFACE_DEDICATED 2'b00
`define IFACE_LINK 2'b10
`define IFACE_GCI 2'b11
`define DIAG_LOOPBACK 2'b01
`define DIAG_ECHO 2'b10
`define PRESCALE_LAST 2'b11
`define IDLE_ONES 4'hf
`define MASK_ALL 8'hff

`endif

// *** design/scc_hdlc_pkg.sv ***
package scc_hdlc_pkg;

	typedef struct packed {
		logic [15:0] chan_config;
		logic [15:0] chan_mode;
		logic [15:0] sync_pattern;
		logic [7:0] events;
		logic [7:0] event_mask;
		logic [15:0] slot_mask;
		logic [15:0] iface_setup;
		logic [5:0] pin_meta;
		logic [5:0] pin_sync;
		logic [5:0] pin_prev;
		logic [1:0] pre_cnt;
		logic [10:0] baud_cnt;
		logic baud_tick;
		logic txd_line;
		logic rx_prev_line;
		logic rx_data;
		logic [3:0] ones_cnt;
		logic strobe_one;
		logic strobe_two;
		logic [15:0] rd_data;
	} regs_state_t;

endpackage

// *** design/scc_hdlc_serial_config_regs.sv ***
`timescale 1ns/100ps
`include "scc_hdlc_serial_config_regs_consts.svh"

module scc_hdlc_serial_config_regs (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [11:0] addr_i,
	input wire logic [15:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rd_data_o,
	input wire logic cts_n_i,
	input wire logic cd_n_i,
	input wire logic rxd_i,
	input wire logic timer_input_one_i,
	input wire logic tx_clock_pin_i,
	input wire logic rx_clock_pin_i,
	output logic txd_o,
	output logic txd_oe_o,
	output logic rts_n_o,
	input wire logic b1_slot_i,
	input wire logic b2_slot_i,
	output logic strobe_one_o,
	output logic strobe_two_o,
	output logic [1:0] d_route_o,
	output logic [1:0] b1_route_o,
	output logic [1:0] b2_route_o,
	output logic [1:0] iface_mode_o,
	output logic [7:0] b1_bit_mask_o,
	output logic [7:0] b2_bit_mask_o,
	input wire logic tx_bit_i,
	input wire logic tx_frame_active_i,
	input wire logic tx_underrun_i,
	input wire logic rx_frame_done_i,
	input wire logic rx_no_buffer_i,
	input wire logic tx_buffer_done_i,
	input wire logic tx_bd_irq_i,
	input wire logic rx_buffer_done_i,
	input wire logic rx_bd_irq_i,
	output logic tx_tick_o,
	output logic rx_tick_o,
	output logic rx_data_o,
	output logic [3:0] min_flags_o,
	output logic shared_flag_o,
	output logic idle_flags_o,
	output logic crc32_o,
	output logic retransmit_o,
	output logic [1:0] diag_mode_o,
	output logic [1:0] protocol_o,
	output logic [15:0] sync_pattern_o,
	output logic event_request_o
);

	localparam scc_hdlc_pkg::regs_state_t RESET_STATE = '{
		chan_config: `RST_ZERO16,
		chan_mode: `RST_ZERO16,
		sync_pattern: `RST_SYNC_PATTERN,
		events: `RST_ZERO8,
		event_mask: `RST_ZERO8,
		slot_mask: `RST_ZERO16,
		iface_setup: `RST_ZERO16,
		pin_meta: 6'h3f,
		pin_sync: 6'h3f,
		pin_prev: 6'h3f,
		pre_cnt: 2'h0,
		baud_cnt: 11'h000,
		baud_tick: 1'b0,
		txd_line: 1'b1,
		rx_prev_line: 1'b1,
		rx_data: 1'b1,
		ones_cnt: 4'h0,
		strobe_one: 1'b0,
		strobe_two: 1'b0,
		rd_data: `RST_ZERO16
	};

	scc_hdlc_pkg::regs_state_t state;
	scc_hdlc_pkg::regs_state_t next_state;

	logic [5:0] pin_rise;
	logic [5:0] pin_change;
	logic tx_en;
	logic rx_en;
	logic src_tick;
	logic pre_tick;
	logic tx_tick;
	logic rx_tick;
	logic line_idle;
	logic [1:0] diag;
	logic [7:0] event_set;
	logic [7:0] event_clear;
	logic [2:0] line_status;
	logic rx_line;
	logic [3:0] flag_count;
	logic cfg_wr;

	function automatic logic [1:0] eff_route(input logic [1:0] route, input logic ch2_off,
			input logic ch3_off);
		eff_route = route;
		if ((route == `ROUTE_CH2 && ch2_off) || (route == `ROUTE_CH3 && ch3_off)) begin
			eff_route = `ROUTE_NONE;
		end
	endfunction

	// edges compare the second stage with the third, never the first
	assign pin_rise = state.pin_sync & ~state.pin_prev;
	assign pin_change = state.pin_sync ^ state.pin_prev;
	assign tx_en = state.chan_mode[`MODE_TX_EN];
	assign rx_en = state.chan_mode[`MODE_RX_EN];
	assign diag = state.chan_mode[`MODE_DIAG_HI:`MODE_DIAG_LO];
	assign flag_count = state.chan_mode[`MODE_FLAGS_HI:`MODE_FLAGS_LO];

	// timer pin edge is limited to half the main clock rate by the synchroniser
	assign src_tick = state.chan_config[`CFG_EXT_BAUD] ? pin_rise[`PIN_TIMER] : 1'b1;
	assign pre_tick = src_tick &&
		(!state.chan_config[`CFG_PRESCALE4] || state.pre_cnt == `PRESCALE_LAST);

	assign tx_tick = tx_en && (state.chan_config[`CFG_TX_CLK_SEL] ?
		pin_rise[`PIN_TX_CLOCK_PIN] : state.baud_tick);
	assign rx_tick = rx_en && (state.chan_config[`CFG_RX_CLK_SEL] ?
		pin_rise[`PIN_RCLK] : state.baud_tick);

	// loopback feeds the receiver from our own transmit line
	assign rx_line = (diag == `DIAG_LOOPBACK) ? state.txd_line : state.pin_sync[`PIN_RXD];
	assign line_idle = state.ones_cnt == `IDLE_ONES;

	assign line_status = {line_idle || state.pin_sync[`PIN_CD], state.pin_sync[`PIN_CD],
		state.pin_sync[`PIN_CTS]};

	always_comb begin
		event_set = 8'h00;
		event_set[`EV_CTS] = pin_change[`PIN_CTS];
		event_set[`EV_CD] = pin_change[`PIN_CD];
		// idle change is worked out from the current count, not from next_state
		event_set[`EV_IDLE] = rx_tick && (line_idle ? !rx_line :
			(rx_line && state.ones_cnt + 4'h1 == `IDLE_ONES));
		event_set[`EV_TX_ERROR] = tx_en && (tx_underrun_i ||
			(tx_frame_active_i && pin_rise[`PIN_CTS]));
		event_set[`EV_RX_FRAME] = rx_en && rx_frame_done_i;
		event_set[`EV_NO_BUFFER] = rx_en && rx_no_buffer_i;
		event_set[`EV_TX_BUFFER] = tx_en && tx_buffer_done_i && tx_bd_irq_i;
		event_set[`EV_RX_BUFFER] = rx_en && rx_buffer_done_i && rx_bd_irq_i;
	end

	assign event_clear = (wr_i && addr_i == `OFS_CHANNEL_EVENTS) ? wr_data_i[7:0] : 8'h00;
	assign cfg_wr = wr_i && addr_i == `OFS_CHANNEL_CONFIG;

	always_comb begin
		next_state = state;
		next_state.pin_meta = {rx_clock_pin_i, tx_clock_pin_i, timer_input_one_i, rxd_i,
			cd_n_i, cts_n_i};
		next_state.pin_sync = state.pin_meta;
		next_state.pin_prev = state.pin_sync;

		// baud generator
		next_state.baud_tick = 1'b0;
		if (src_tick && state.chan_config[`CFG_PRESCALE4]) begin
			next_state.pre_cnt = state.pre_cnt + 2'h1;
		end
		if (pre_tick) begin
			if (state.baud_cnt == 11'h000) begin
				next_state.baud_cnt = state.chan_config[`CFG_DIV_HI:`CFG_DIV_LO];
				next_state.baud_tick = 1'b1;
			end else begin
				next_state.baud_cnt = state.baud_cnt - 11'h001;
			end
		end

		// transmit line: echo, idle mark, or coded data
		if (diag == `DIAG_ECHO) begin
			next_state.txd_line = state.pin_sync[`PIN_RXD];
		end else if (!tx_en) begin
			next_state.txd_line = 1'b1;
		end else if (tx_tick) begin
			// nrzi toggles the line on a zero
			next_state.txd_line = state.chan_mode[`MODE_NRZI] ?
				(tx_bit_i ? state.txd_line : ~state.txd_line) : tx_bit_i;
		end

		// receive sampling, decoding and idle detection
		if (rx_tick) begin
			next_state.rx_prev_line = rx_line;
			next_state.rx_data = state.chan_mode[`MODE_NRZI] ?
				~(rx_line ^ state.rx_prev_line) : rx_line;
			if (!rx_line) begin
				next_state.ones_cnt = 4'h0;
			end else if (!line_idle) begin
				next_state.ones_cnt = state.ones_cnt + 4'h1;
			end
		end

		next_state.strobe_one = (b1_slot_i && !state.iface_setup[`SI_B1_STROBE_SWAP]) ||
			(b2_slot_i && state.iface_setup[`SI_B2_STROBE_SWAP]);
		next_state.strobe_two = (b1_slot_i && state.iface_setup[`SI_B1_STROBE_SWAP]) ||
			(b2_slot_i && !state.iface_setup[`SI_B2_STROBE_SWAP]);

		// a set arriving with its clear still lands
		next_state.events = (state.events & ~event_clear) | event_set;

		if (wr_i) begin
			case (addr_i)
				`OFS_CHANNEL_CONFIG: begin
					next_state.chan_config = wr_data_i;
				end
				`OFS_CHANNEL_MODE: begin
					next_state.chan_mode = wr_data_i;
				end
				`OFS_SYNC_PATTERN: begin
					next_state.sync_pattern = wr_data_i;
				end
				`OFS_EVENT_MASK: begin
					next_state.event_mask = wr_data_i[7:0];
				end
				`OFS_TIMESLOT_MASK: begin
					next_state.slot_mask = wr_data_i;
				end
				`OFS_IFACE_SETUP: begin
					next_state.iface_setup = wr_data_i;
				end
				default: begin
				end
			endcase
		end

		next_state.rd_data = 16'h0000;
		if (rd_i) begin
			case (addr_i)
				`OFS_CHANNEL_CONFIG: begin
					next_state.rd_data = state.chan_config;
				end
				`OFS_CHANNEL_MODE: begin
					next_state.rd_data = state.chan_mode;
				end
				`OFS_SYNC_PATTERN: begin
					next_state.rd_data = state.sync_pattern;
				end
				`OFS_CHANNEL_EVENTS: begin
					next_state.rd_data = {8'h00, state.events};
				end
				`OFS_EVENT_MASK: begin
					next_state.rd_data = {8'h00, state.event_mask};
				end
				`OFS_LINE_STATUS: begin
					next_state.rd_data = {13'h0000, line_status};
				end
				`OFS_TIMESLOT_MASK: begin
					next_state.rd_data = state.slot_mask;
				end
				`OFS_IFACE_SETUP: begin
					next_state.rd_data = state.iface_setup;
				end
				default: begin
					next_state.rd_data = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= RESET_STATE;
		end else begin
			state <= next_state;
		end
	end

	assign rd_data_o = state.rd_data;

	// open drain only ever pulls low; the wire supplies the high
	assign txd_o = state.chan_config[`CFG_WIRED_OR] ? 1'b0 : state.txd_line;
	assign txd_oe_o = state.chan_config[`CFG_WIRED_OR] ? ~state.txd_line : 1'b1;

	assign rts_n_o = !(tx_en && (state.chan_mode[`MODE_IDLE_FLAG] || tx_frame_active_i));
	assign idle_flags_o = state.chan_mode[`MODE_IDLE_FLAG];

	assign min_flags_o = (state.chan_mode[`MODE_FLAG_SHARE] && flag_count != 4'h0) ?
		flag_count - 4'h1 : flag_count;
	assign shared_flag_o = state.chan_mode[`MODE_FLAG_SHARE] && flag_count == 4'h0;

	assign strobe_one_o = state.strobe_one;
	assign strobe_two_o = state.strobe_two;

	assign d_route_o = eff_route(state.iface_setup[`SI_D_ROUTE_HI:`SI_D_ROUTE_LO],
		state.iface_setup[`SI_CHAN2_DISC], state.iface_setup[`SI_CHAN3_DISC]);
	assign b1_route_o = eff_route(state.iface_setup[`SI_B1_ROUTE_HI:`SI_B1_ROUTE_LO],
		state.iface_setup[`SI_CHAN2_DISC], state.iface_setup[`SI_CHAN3_DISC]);
	assign b2_route_o = eff_route(state.iface_setup[`SI_B2_ROUTE_HI:`SI_B2_ROUTE_LO],
		state.iface_setup[`SI_CHAN2_DISC], state.iface_setup[`SI_CHAN3_DISC]);

	assign iface_mode_o = state.iface_setup[`SI_MODE_HI:`SI_MODE_LO];
	assign b1_bit_mask_o = (iface_mode_o == `IFACE_LINK || iface_mode_o == `IFACE_GCI) ?
		state.slot_mask[7:0] : `MASK_ALL;
	assign b2_bit_mask_o = (iface_mode_o == `IFACE_LINK || iface_mode_o == `IFACE_GCI) ?
		state.slot_mask[15:8] : `MASK_ALL;

	assign tx_tick_o = tx_tick;
	assign rx_tick_o = rx_tick;
	assign rx_data_o = state.rx_data;
	assign crc32_o = state.chan_mode[`MODE_CRC32];
	assign retransmit_o = state.chan_mode[`MODE_RETRANSMIT];
	assign diag_mode_o = diag;
	assign protocol_o = state.chan_mode[`MODE_PROTO_HI:`MODE_PROTO_LO];
	assign sync_pattern_o = state.sync_pattern;
	assign event_request_o = |(state.events & state.event_mask);

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence baud_quiet_s;
		!state.baud_tick ##1 !state.baud_tick;
	endsequence

	// config must stand still around the tick so that the reload value is known
	sequence baud_fixed_s;
		state.baud_tick && !state.chan_config[`CFG_EXT_BAUD] &&
		!state.chan_config[`CFG_PRESCALE4] &&
		state.chan_config[`CFG_DIV_HI:`CFG_DIV_LO] == 11'h002 && !cfg_wr && !$past(cfg_wr)
		##1 !cfg_wr;
	endsequence

	strobe_swap_a: assert property (
		b1_slot_i && !b2_slot_i && state.iface_setup[`SI_B1_STROBE_SWAP] && !wr_i
		|=> strobe_two_o && !strobe_one_o)
		else $error("b1 strobe not moved to strobe two");
	route_detach_a: assert property (
		state.iface_setup[`SI_B1_ROUTE_HI:`SI_B1_ROUTE_LO] == `ROUTE_CH2 &&
		state.iface_setup[`SI_CHAN2_DISC] |-> b1_route_o == `ROUTE_NONE)
		else $error("detached channel two still routed");
	mask_mode_a: assert property (
		iface_mode_o == `IFACE_DEDICATED |-> b1_bit_mask_o == 8'hff && b2_bit_mask_o == 8'hff)
		else $error("bit mask applied outside link modes");
	open_drain_a: assert property (
		state.chan_config[`CFG_WIRED_OR] |-> !(txd_oe_o && txd_o))
		else $error("open drain driver drove high");
	baud_period_a: assert property (
		baud_fixed_s |-> baud_quiet_s ##1 state.baud_tick)
		else $error("baud tick period wrong for divider two");
	share_flag_a: assert property (
		state.chan_mode[`MODE_FLAG_SHARE] && flag_count == 4'h5 |-> min_flags_o == 4'h4)
		else $error("shared flag count not reduced");
	rts_idle_a: assert property (
		!state.chan_mode[`MODE_IDLE_FLAG] && !tx_frame_active_i |-> rts_n_o)
		else $error("request to send asserted while idling ones");
	tx_disabled_a: assert property (
		!tx_en && diag != `DIAG_ECHO ##1 !tx_en |-> !tx_tick_o && state.txd_line)
		else $error("transmitter active while disabled");
	event_keep_a: assert property (
		state.events[`EV_RX_BUFFER] && wr_i && addr_i == `OFS_CHANNEL_EVENTS &&
		!wr_data_i[`EV_RX_BUFFER] |=> state.events[`EV_RX_BUFFER])
		else $error("event lost on write of zero");
	event_set_wins_a: assert property (
		tx_en && tx_buffer_done_i && tx_bd_irq_i |=> state.events[`EV_TX_BUFFER] ##1 1'b1)
		else $error("buffer event not latched");
	cts_event_a: assert property (
		$changed(state.pin_sync[`PIN_CTS]) |=> state.events[`EV_CTS])
		else $error("clear to send change not recorded");
	request_gate_a: assert property (
		(state.events & state.event_mask) == 8'h00 |-> !event_request_o)
		else $error("interrupt request with all masked");

endmodule

// *** verif/serial_line_model.sv ***
`timescale 1ns/100ps

module serial_line_model (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic run_clk_i,
	input wire logic cts_n_lvl_i,
	input wire logic cd_n_lvl_i,
	input wire logic txd_i,
	input wire logic txd_oe_i,
	output logic cts_n_o,
	output logic cd_n_o,
	output logic rxd_o,
	output logic line_clk_o
);
	logic [2:0] div_cnt;

	// shared line has a pull-up: a released driver reads back as one
	assign rxd_o = txd_oe_i ? txd_i : 1'b1;
	assign cts_n_o = cts_n_lvl_i;
	assign cd_n_o = cd_n_lvl_i;
	assign line_clk_o = div_cnt[2];

	// pin clock stands still low outside runs, eight main clocks a period
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_cnt <= 3'h0;
		end else if (run_clk_i) begin
			div_cnt <= div_cnt + 3'h1;
		end else begin
			div_cnt <= 3'h0;
		end
	end
endmodule

// *** verif/tb_scc_hdlc_serial_config_regs.sv ***
`timescale 1ns/100ps
`include "scc_hdlc_serial_config_regs_consts.svh"

module tb_scc_hdlc_serial_config_regs;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic run_clk = 1'b0;
	logic cts_lvl = 1'b1;
	logic cd_lvl = 1'b1;
	logic b1s = 1'b0;
	logic b2s = 1'b0;
	logic [4:0] evp = 5'h00;
	logic bd_irq = 1'b0;
	logic frame_act = 1'b0;
	logic tx_bit = 1'b0;
	logic [15:0] rdata;
	logic [15:0] d;
	logic [15:0] m;
	logic [1:0] c;
	logic cts_n, cd_n, rxd, lclk, txd, txd_oe, rts_n, s1, s2, tx_tick, rx_tick;
	logic [1:0] d_rt, b1_rt, b2_rt, imode, diag, proto;
	logic [7:0] b1_msk, b2_msk;
	logic [3:0] min_flags;
	logic crc32, retransmit_enable, ev_req, rx_dat, shared_fl, idle_fl;
	logic [15:0] sync_pat;
	int n;
	int fail_count = 0;
	int n_checks = 0;
	logic [15:0] cfg_tab [5] = '{16'h0004, 16'h0005, 16'h2000, 16'h4000, 16'h1000};
	int exp_tab [5] = '{3, 12, 8, 8, 8};

	always #50 core_clk = ~core_clk;

	serial_line_model line (.core_clk_i(core_clk), .resetn_i(resetn), .run_clk_i(run_clk),
		.cts_n_lvl_i(cts_lvl), .cd_n_lvl_i(cd_lvl), .txd_i(txd), .txd_oe_i(txd_oe),
		.cts_n_o(cts_n), .cd_n_o(cd_n), .rxd_o(rxd), .line_clk_o(lclk));

	scc_hdlc_serial_config_regs uut (.core_clk_i(core_clk), .resetn_i(resetn), .addr_i(addr),
		.wr_data_i(wdata), .wr_i(wr), .rd_i(rd), .rd_data_o(rdata), .cts_n_i(cts_n),
		.cd_n_i(cd_n), .rxd_i(rxd), .timer_input_one_i(lclk), .tx_clock_pin_i(lclk),
		.rx_clock_pin_i(lclk), .txd_o(txd), .txd_oe_o(txd_oe), .rts_n_o(rts_n),
		.b1_slot_i(b1s), .b2_slot_i(b2s), .strobe_one_o(s1), .strobe_two_o(s2),
		.d_route_o(d_rt), .b1_route_o(b1_rt), .b2_route_o(b2_rt), .iface_mode_o(imode),
		.b1_bit_mask_o(b1_msk), .b2_bit_mask_o(b2_msk), .tx_bit_i(tx_bit),
		.tx_frame_active_i(frame_act), .tx_underrun_i(evp[4]), .rx_frame_done_i(evp[1]),
		.rx_no_buffer_i(evp[2]), .tx_buffer_done_i(evp[0]), .tx_bd_irq_i(bd_irq),
		.rx_buffer_done_i(evp[3]), .rx_bd_irq_i(bd_irq), .tx_tick_o(tx_tick),
		.rx_tick_o(rx_tick), .rx_data_o(rx_dat), .min_flags_o(min_flags),
		.shared_flag_o(shared_fl), .idle_flags_o(idle_fl), .crc32_o(crc32),
		.retransmit_o(retransmit_enable), .diag_mode_o(diag),
		.protocol_o(proto), .sync_pattern_o(sync_pat), .event_request_o(ev_req));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [11:0] a, input logic [15:0] v);
		@(posedge core_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
		// one more edge so callers see the written register settled
		@(posedge core_clk);
	endtask

	// read data stand only in the cycle after the strobe; the next edge still sees them
	task automatic rd_chk(input string what, input logic [11:0] a, input logic [15:0] exp,
		input logic [15:0] msk);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		@(posedge core_clk);
		chk(what, exp, rdata & msk);
	endtask

	task automatic pulse(input logic [4:0] v);
		@(posedge core_clk);
		evp <= v;
		@(posedge core_clk);
		evp <= 5'h00;
	endtask

	// cycles to the next tick, zero when none comes within the bound
	task automatic wait_tick(input logic sel, output int cnt);
		cnt = 0;
		for (int i = 1; i <= 40; i++) begin
			@(posedge core_clk);
			if ((sel ? rx_tick : tx_tick) === 1'b1) begin
				cnt = i;
				break;
			end
		end
	endtask

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#(5_000_000);
		fail_count++;
		finish_test();
	end

	initial begin
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		rd_chk("sync reset", `OFS_SYNC_PATTERN, 16'h7e7e, 16'hffff);
		rd_chk("status reset", `OFS_LINE_STATUS, 16'h0007, 16'hffff);
		rd_chk("events reset", `OFS_CHANNEL_EVENTS, 16'h0000, 16'hffff);
		wr_reg(12'h0890, 16'hffff);
		rd_chk("unmapped", 12'h0890, 16'h0000, 16'hffff);
		wr_reg(`OFS_SYNC_PATTERN, 16'h1234);
		rd_chk("sync rw", `OFS_SYNC_PATTERN, 16'h1234, 16'hffff);
		chk("sync out", 16'h1234, sync_pat);
		end_test("registers");
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			wr_reg(`OFS_IFACE_SETUP, {4'h0, c, 10'h000});
			@(posedge core_clk);
			b1s <= 1'b1;
			@(posedge core_clk);
			b1s <= 1'b0;
			@(posedge core_clk);
			chk("b1 strobes", {14'h0000, c[0], !c[0]}, {14'h0000, s2, s1});
			@(posedge core_clk);
			b2s <= 1'b1;
			@(posedge core_clk);
			b2s <= 1'b0;
			@(posedge core_clk);
			chk("b2 strobes", {14'h0000, !c[1], c[1]}, {14'h0000, s2, s1});
		end
		wr_reg(`OFS_TIMESLOT_MASK, 16'ha55a);
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			wr_reg(`OFS_IFACE_SETUP, {14'h00e4, c});
			chk("routes", 16'h00e4 >> 2, {10'h000, b2_rt, b1_rt, d_rt});
			chk("mode", {14'h0000, c}, {14'h0000, imode});
			chk("masks", c[1] ? 16'ha55a : 16'hffff, {b2_msk, b1_msk});
		end
		wr_reg(`OFS_IFACE_SETUP, 16'h03a4);
		chk("detached", 16'h0030, {10'h000, b2_rt, b1_rt, d_rt});
		end_test("serial interface");
		// buffer function codes sit outside this block; the bench never sets one
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			m = {4'(i * 5), c[0], c[1], 1'b0, c[0], 2'b00, c, 2'b11, c};
			wr_reg(`OFS_CHANNEL_MODE, m);
			rd_chk("mode rw", `OFS_CHANNEL_MODE, m, 16'hffff);
			chk("decode", {6'h00, 4'(i * 5 - i / 2), c[0], c[0], c, c},
				{6'h00, min_flags, crc32, retransmit_enable, diag, proto});
		end
		wr_reg(`OFS_CHANNEL_MODE, 16'h5400);
		chk("share five", 16'h0004, {11'h000, shared_fl, min_flags});
		wr_reg(`OFS_CHANNEL_MODE, 16'h0400);
		chk("share zero", 16'h0010, {11'h000, shared_fl, min_flags});
		wr_reg(`OFS_CHANNEL_MODE, 16'h0084);
		chk("rts flags", 16'h0002, {14'h0000, idle_fl, rts_n});
		wr_reg(`OFS_CHANNEL_MODE, 16'h0004);
		chk("rts ones", 16'h0001, {14'h0000, idle_fl, rts_n});
		frame_act <= 1'b1;
		@(posedge core_clk);
		chk("rts frame", 16'h0000, {15'h0000, rts_n});
		frame_act <= 1'b0;
		tx_bit <= 1'b1;
		wr_reg(`OFS_CHANNEL_CONFIG, 16'h8000);
		chk("open drain", 16'h0000, {14'h0000, txd_oe, txd});
		tx_bit <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("open drain low", 16'h0002, {14'h0000, txd_oe, txd});
		tx_bit <= 1'b1;
		wr_reg(`OFS_CHANNEL_CONFIG, 16'h0000);
		chk("push pull", 16'h0003, {14'h0000, txd_oe, txd});
		end_test("mode decode");
		wr_reg(`OFS_CHANNEL_MODE, 16'h000c);
		run_clk <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			wr_reg(`OFS_CHANNEL_CONFIG, cfg_tab[i]);
			wait_tick(i == 4, n);
			wait_tick(i == 4, n);
			chk("tick period", 16'(exp_tab[i]), 16'(n));
		end
		run_clk <= 1'b0;
		wr_reg(`OFS_CHANNEL_CONFIG, 16'h0000);
		wr_reg(`OFS_CHANNEL_MODE, 16'h0000);
		wait_tick(1'b0, n);
		chk("no tick off", 16'h0000, 16'(n));
		end_test("baud");
		wr_reg(`OFS_CHANNEL_MODE, 16'h000c);
		wr_reg(`OFS_EVENT_MASK, 16'hffff);
		rd_chk("mask width", `OFS_EVENT_MASK, 16'h00ff, 16'hffff);
		wr_reg(`OFS_EVENT_MASK, 16'h0002);
		wr_reg(`OFS_CHANNEL_EVENTS, 16'h00ff);
		pulse(5'h01);
		rd_chk("no bd irq", `OFS_CHANNEL_EVENTS, 16'h0000, 16'h001f);
		bd_irq <= 1'b1;
		pulse(5'h01);
		rd_chk("tx buffer", `OFS_CHANNEL_EVENTS, 16'h0002, 16'h001f);
		chk("request", 16'h0001, {15'h0000, ev_req});
		wr_reg(`OFS_CHANNEL_EVENTS, 16'h0000);
		rd_chk("write zero", `OFS_CHANNEL_EVENTS, 16'h0002, 16'h001f);
		wr_reg(`OFS_CHANNEL_EVENTS, 16'h0002);
		rd_chk("write one", `OFS_CHANNEL_EVENTS, 16'h0000, 16'h001f);
		pulse(5'h1e);
		rd_chk("events", `OFS_CHANNEL_EVENTS, 16'h001d, 16'h001f);
		chk("masked", 16'h0000, {15'h0000, ev_req});
		end_test("events");
		wr_reg(`OFS_CHANNEL_EVENTS, 16'h00ff);
		cts_lvl <= 1'b0;
		repeat (6) @(posedge core_clk);
		rd_chk("cts change", `OFS_CHANNEL_EVENTS, 16'h0080, 16'h00c0);
		wr_reg(`OFS_CHANNEL_EVENTS, 16'h00ff);
		cd_lvl <= 1'b0;
		repeat (6) @(posedge core_clk);
		rd_chk("cd change", `OFS_CHANNEL_EVENTS, 16'h0040, 16'h00c0);
		rd_chk("status live", `OFS_LINE_STATUS, 16'h0000, 16'h0003);
		end_test("line events");
		tx_bit <= 1'b0;
		wr_reg(`OFS_CHANNEL_MODE, 16'h004c);
		repeat (6) @(posedge core_clk);
		d = {14'h0000, txd, rx_dat};
		@(posedge core_clk);
		chk("nrzi zero", {14'h0000, ~d[1], 1'b0}, {14'h0000, txd, rx_dat});
		chk("nrzi zero rx", 16'h0000, d & 16'h0001);
		tx_bit <= 1'b1;
		repeat (6) @(posedge core_clk);
		d = {14'h0000, txd, rx_dat};
		@(posedge core_clk);
		chk("nrzi one", {d[15:1], 1'b1}, {14'h0000, txd, rx_dat});
		wr_reg(`OFS_CHANNEL_MODE, 16'h000c);
		repeat (24) @(posedge core_clk);
		rd_chk("idle status", `OFS_LINE_STATUS, 16'h0004, 16'h0004);
		wr_reg(`OFS_CHANNEL_EVENTS, 16'h00ff);
		tx_bit <= 1'b0;
		repeat (6) @(posedge core_clk);
		rd_chk("idle event", `OFS_CHANNEL_EVENTS, 16'h0020, 16'h0020);
		rd_chk("busy status", `OFS_LINE_STATUS, 16'h0000, 16'h0004);
		end_test("coding");
		finish_test();
	end
endmodule
